//--- design/tmsr_pkg.sv
// Package: register map, field layout and mode encodings for the timer mode registers
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
package tmsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_MODE_A = 12'h004;
  localparam logic [11:0] OFS_MODE_B = 12'h008;
  localparam logic [11:0] OFS_WIDTH  = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h010;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int MODE_LSB   = 0;
  localparam int MODE_MSB   = 1;
  localparam int CKIND_BIT  = 2;
  localparam int ALT_BIT    = 3;
  localparam int MODE_REG_W = 4;
  localparam int CFG_W      = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_REG_RST = 4'h0;
  localparam logic [2:0] CFG_RST      = 3'h0;

  // ----------------------------------------------------------------
  // Width configuration and mode encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] CFG_32BIT = 3'h0;

  typedef enum logic [1:0] {
    TMSR_MODE_RSVD     = 2'h0,
    TMSR_MODE_ONESHOT  = 2'h1,
    TMSR_MODE_PERIODIC = 2'h2,
    TMSR_MODE_CAPTURE  = 2'h3
  } tmsr_mode_e;

  typedef enum logic [2:0] {
    TMSR_OP_OFF      = 3'h0,
    TMSR_OP_ONESHOT  = 3'h1,
    TMSR_OP_PERIODIC = 3'h3,
    TMSR_OP_CNT_CAP  = 3'h2,
    TMSR_OP_TIME_CAP = 3'h6,
    TMSR_OP_PWM      = 3'h7
  } tmsr_op_e;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage : tmsr_pkg

//--- design/tmsr_mode_if.sv
// Interface: one sub-timer's raw mode fields and its decoded operation
// Assumes: fields and active driven by the register block, op and rsvd driven by the decoder
`timescale 1ns/1ps
interface tmsr_mode_if;
  logic [3:0]         fields;
  logic               active;
  tmsr_pkg::tmsr_op_e op;
  logic               rsvd;
  modport regs (output fields, output active, input op, input rsvd);
  modport dec  (input fields, input active, output op, output rsvd);
endinterface : tmsr_mode_if

//--- design/tmsr_decode.sv
// Holds: decoder from one sub-timer's mode fields to its operation
// Assumes: fields are stable register outputs
`timescale 1ns/1ps
module tmsr_decode (
  // Mode fields in, operation out
  tmsr_mode_if.dec m
);
  logic [1:0] mode;

  always_comb begin
    mode   = m.fields[tmsr_pkg::MODE_MSB:tmsr_pkg::MODE_LSB];
    m.op   = tmsr_pkg::TMSR_OP_OFF;
    m.rsvd = 1'b0;
    if (m.active) begin
      case (mode)
        tmsr_pkg::TMSR_MODE_ONESHOT:  m.op = tmsr_pkg::TMSR_OP_ONESHOT; // R1
        tmsr_pkg::TMSR_MODE_PERIODIC: begin
          if (m.fields[tmsr_pkg::ALT_BIT]) begin
            m.op = tmsr_pkg::TMSR_OP_PWM; // R8
          end else begin
            m.op = tmsr_pkg::TMSR_OP_PERIODIC; // R1
          end
        end
        tmsr_pkg::TMSR_MODE_CAPTURE: begin
          if (m.fields[tmsr_pkg::ALT_BIT]) begin
            m.op = tmsr_pkg::TMSR_OP_PWM; // R8
          end else if (m.fields[tmsr_pkg::CKIND_BIT]) begin
            m.op = tmsr_pkg::TMSR_OP_TIME_CAP; // R9
          end else begin
            m.op = tmsr_pkg::TMSR_OP_CNT_CAP; // R9
          end
        end
        default: m.rsvd = 1'b1; // R1
      endcase
    end
  end
endmodule : tmsr_decode

//--- design/tmsr_top.sv
// Holds: AHB-Lite register slave for the timer mode registers and mode selection
// Assumes: single-word transfers, hready equals this slave's hreadyout
`timescale 1ns/1ps

// What this block does
// R1 - The first mode field decodes 1 to one-shot, 2 to periodic, 3 to capture, and 0 is reserved.
// R2 - The selected mode is applied together with the 3-bit width configuration field.
// R3 - In 16-bit configuration the first mode field governs only the first sub-timer.
// R4 - In 32-bit configuration only the first mode register counts and the second is ignored.
// R5 - Software sets alternate 1, capture kind 0 and mode 2 to run the second sub-timer as PWM.
// R6 - The second mode register holds alternate select at bit 3, capture kind at 2, mode at 1:0, reset 0.
// R7 - Bits 31:4 of the second mode register read as zero and ignore writes.
// R8 - Alternate select set means PWM in periodic and capture mode; clear means capture in capture mode, periodic in periodic mode.
// R9 - Capture kind select clear means edge-count, set means edge-time.
module tmsr_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Decoded operation
  output logic [2:0]       op_first,
  output logic [2:0]       op_second,
  output logic             wide_mode
);

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  logic        wr_pend;
  logic        next_wr_pend;
  logic [11:0] wr_addr;
  logic [11:0] next_wr_addr;
  logic        take;

  assign take = hsel && hready && (htrans == tmsr_pkg::HTRANS_NONSEQ || htrans == tmsr_pkg::HTRANS_SEQ);

  always_comb begin
    next_wr_pend = take && hwrite;
    next_wr_addr = take ? haddr : wr_addr;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0] mode_a;
  logic [3:0] mode_b;
  logic [2:0] width_cfg;
  logic [3:0] next_mode_a;
  logic [3:0] next_mode_b;
  logic [2:0] next_width_cfg;

  always_comb begin
    next_mode_a    = mode_a;
    next_mode_b    = mode_b;
    next_width_cfg = width_cfg;
    if (wr_pend) begin
      case (wr_addr)
        tmsr_pkg::OFS_MODE_A: next_mode_a = hwdata[3:0];
        tmsr_pkg::OFS_MODE_B: next_mode_b = hwdata[3:0]; // R6 R7
        tmsr_pkg::OFS_WIDTH:  next_width_cfg = hwdata[2:0]; // R2
        default:              next_mode_a = mode_a;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_a    <= tmsr_pkg::MODE_REG_RST;
      mode_b    <= tmsr_pkg::MODE_REG_RST; // R6
      width_cfg <= tmsr_pkg::CFG_RST;
    end else begin
      mode_a    <= next_mode_a;
      mode_b    <= next_mode_b;
      width_cfg <= next_width_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  logic        wide;
  tmsr_mode_if ma ();
  tmsr_mode_if mb ();

  assign wide      = (width_cfg == tmsr_pkg::CFG_32BIT); // R2
  assign ma.fields = mode_a; // R3 R4
  assign ma.active = 1'b1;
  assign mb.fields = mode_b;
  assign mb.active = !wide; // R4

  tmsr_decode u_dec_a (
    .m (ma)
  );

  tmsr_decode u_dec_b (
    .m (mb)
  );

  // ----------------------------------------------------------------
  // Read data and status
  // ----------------------------------------------------------------
  logic [31:0] next_hrdata;
  logic [2:0]  next_op_first;
  logic [2:0]  next_op_second;

  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (take && !hwrite) begin
      case (haddr)
        tmsr_pkg::OFS_MODE_A: next_hrdata = {28'h000_0000, mode_a};
        tmsr_pkg::OFS_MODE_B: next_hrdata = {28'h000_0000, mode_b}; // R7
        tmsr_pkg::OFS_WIDTH:  next_hrdata = {29'h0, width_cfg};
        tmsr_pkg::OFS_STATUS: next_hrdata = {24'h00_0000, mb.rsvd, ma.rsvd, op_second, op_first};
        default:              next_hrdata = 32'h0000_0000;
      endcase
    end
    next_op_first  = ma.op; // R3
    next_op_second = wide ? tmsr_pkg::TMSR_OP_OFF : mb.op; // R4
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      op_first  <= 3'h0;
      op_second <= 3'h0;
      wide_mode <= 1'b1;
    end else begin
      hrdata    <= next_hrdata;
      op_first  <= next_op_first;
      op_second <= next_op_second;
      wide_mode <= wide;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : tmsr_top

//--- sim/tmsr_assertions.sv
// Checker: mode decode and register relations of tmsr_top
// Assumes: bound to tmsr_top, hready fed from hreadyout
`timescale 1ns/1ps
module tmsr_chk (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Decode
  input wire logic [2:0]  op_first,
  input wire logic [2:0]  op_second,
  input wire logic        wide_mode
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        v;
  logic        w;
  logic [11:0] a;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      v <= 1'b0;
      w <= 1'b0;
      a <= 12'h000;
    end else if (hready) begin
      v <= hsel && htrans[1];
      w <= hwrite;
      a <= haddr;
    end
  end
  wire wa = v && w && a == 12'h004;
  wire wb = v && w && a == 12'h008 && !wide_mode;
  wire ww = v && w && a == 12'h000;
  AST_ONESHOT: assert property (wa && hwdata[1:0] == 2'h1 |=> ##1 op_first == 3'h1)
    else $error("one-shot decode");
  AST_RSVD: assert property (wa && hwdata[1:0] == 2'h0 |=> ##1 op_first == 3'h0)
    else $error("reserved decode");
  AST_TIMECAP: assert property (wa && hwdata[3:0] == 4'h7 |=> ##1 op_first == 3'h6)
    else $error("edge-time decode");
  AST_WIDE: assert property (ww && hwdata[2:0] == 3'h0 |=> ##1 wide_mode)
    else $error("wide mode not set");
  AST_NARROW: assert property (ww && hwdata[2:0] != 3'h0 |=> ##1 !wide_mode)
    else $error("wide mode not cleared");
  AST_IGNORE: assert property (wide_mode |-> op_second == 3'h0)
    else $error("second mode used when wide");
  AST_BPWM: assert property (wb && hwdata[3:0] == 4'hA |=> ##1 op_second == 3'h7)
    else $error("second pwm decode");
  AST_RDZERO: assert property (v && !w && a == 12'h008 |-> hrdata[31:4] == 28'h0)
    else $error("upper bits not zero");
endmodule : tmsr_chk
bind tmsr_top tmsr_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .op_first(op_first),
  .op_second(op_second), .wide_mode(wide_mode));

//--- sim/tb_top.sv
// Testbench: register access and mode decode of tmsr_top
// Assumes: one AHB-Lite master, hready fed from hreadyout
`timescale 1ns/1ps
module tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r;
  logic        hreadyout, hresp, wide_mode;
  logic [2:0]  op_first, op_second;
  logic [3:0]  fv [8] = '{4'h0, 4'h1, 4'hD, 4'h2, 4'h3, 4'h7, 4'hA, 4'hB};
  logic [2:0]  fe [8] = '{3'h0, 3'h1, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h7};
  int          fail_count = 0;
  int          n_tests = 0;
  always #10 hclk = ~hclk;
  tmsr_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(tmsr_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .op_first(op_first), .op_second(op_second), .wide_mode(wide_mode));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %0t %s", $time, what);
      fail_count++;
    end
  endtask : chk
  task automatic bus(input logic [11:0] ad, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= wr;
    htrans <= tmsr_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic settle;
    @(posedge hclk);
    #1;
  endtask : settle
  task automatic t_reset;
    chk(wide_mode, 1'b1, "wide after reset");
    chk(op_second, 3'h0, "second op after reset");
    bus(12'h008, 1'b0, 32'h0);
    chk(r, 32'h0, "second mode reset");
    chk(hresp, 1'b0, "okay response");
    chk(hreadyout, 1'b1, "ready always high");
    $display("test reset done");
  endtask : t_reset
  task automatic t_first;
    for (int i = 0; i < 8; i++) begin
      bus(12'h004, 1'b1, {28'h0, fv[i]});
      settle();
      chk(op_first, fe[i], "first op decode");
    end
    $display("test first done");
  endtask : t_first
  task automatic t_width;
    bus(12'h008, 1'b1, 32'hA);
    settle();
    chk(op_second, 3'h0, "second ignored when wide");
    bus(12'h000, 1'b1, 32'h5);
    settle();
    chk(wide_mode, 1'b0, "narrow width");
    chk(op_second, 3'h7, "second pwm");
    bus(12'h008, 1'b1, 32'h0);
    settle();
    bus(12'h008, 1'b1, 32'hA);
    settle();
    chk(op_second, 3'h7, "second pwm rewritten");
    bus(12'h008, 1'b1, 32'h2);
    settle();
    chk(op_second, 3'h3, "second periodic");
    bus(12'h008, 1'b1, 32'h7);
    settle();
    chk(op_second, 3'h6, "second edge-time");
    chk(op_first, 3'h7, "first kept");
    bus(12'h000, 1'b1, 32'h0);
    settle();
    chk(wide_mode, 1'b1, "wide again");
    chk(op_second, 3'h0, "second ignored again");
    $display("test width done");
  endtask : t_width
  task automatic t_regb;
    bus(12'h008, 1'b1, 32'hFFFFFFFF);
    bus(12'h008, 1'b0, 32'h0);
    chk(r, 32'hF, "upper bits read zero");
    bus(12'h0FC, 1'b0, 32'h0);
    chk(r, 32'h0, "unmapped reads zero");
    bus(12'h004, 1'b1, 32'h0);
    settle();
    bus(12'h010, 1'b0, 32'h0);
    chk(r, 32'h40, "status reserved flag");
    $display("test regb done");
  endtask : t_regb
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_first();
    t_width();
    t_regb();
    finish_test();
  end
  initial begin
    repeat (2000) @(posedge hclk);
    fail_count++;
    finish_test();
  end
endmodule : tb_top
